/* File: trk_load_balance.sv */
`timescale 1ns/1ps
`default_nettype none
module trk_load_balance
  import trk_pkg::*;
#(
  parameter int NPORT = 8
) (
  // clock, reset, enable
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  input  wire logic             CE,
  // wishbone classic slave
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [7:0]       WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic      [31:0]      WB_DAT_O,
  output logic                  WB_ACK_O,
  // per-port link status from the MACs, asynchronous
  input  wire logic [NPORT-1:0] LINK_UP,
  // packet request from the forwarding engine
  input  wire logic             REQ_VALID,
  input  wire logic             REQ_TRUNK_B,
  input  wire logic [3:0]       REQ_SRC_PORT,
  input  wire logic [2:0]       REQ_SA,
  input  wire logic [2:0]       REQ_DA,
  input  wire logic [3:0]       REQ_SIP,
  input  wire logic [3:0]       REQ_DIP,
  input  wire logic [3:0]       REQ_L4_SRC,
  input  wire logic [3:0]       REQ_L4_DST,
  input  wire logic             REQ_IS_IP,
  input  wire logic             REQ_IS_L4,
  // chosen egress member
  output logic                  RSP_VALID,
  output logic      [NPORT-1:0] RSP_PORT_MASK,
  output logic      [2:0]       RSP_INDEX,
  output logic                  RSP_FAILOVER
);

  localparam int IW = 3;

  if (NPORT != 8) begin : g_bad_nport
    $error("trk_load_balance: membership byte serves exactly eight ports");
  end
  // member positions and hash identifiers share one index width
  if (TRK_DOUBLE_HW != IW || TRK_SINGLE_HW >= IW) begin : g_bad_hw
    $error("trk_load_balance: hash widths do not fit the member index");
  end
  // the result registers give exactly one cycle from request to result
  if (TRK_SEL_LATENCY != 1) begin : g_bad_lat
    $error("trk_load_balance: selection is registered exactly once");
  end

  function automatic logic [2:0] mac_hash(input logic [2:0] a, input logic dbl);
    mac_hash = dbl ? a : {1'b0, a[1:0]};
  endfunction

  function automatic logic [2:0] fold_hash(input logic [3:0] x, input logic dbl);
    fold_hash = dbl ? {x[2] ^ x[1], x[3] ^ x[2], x[1] ^ x[0]}
                    : {1'b0, x[3] ^ x[2], x[1] ^ x[0]};
  endfunction

  function automatic logic [IW-1:0] member_port(input logic [NPORT*IW-1:0] tbl,
                                                input logic [IW-1:0]       pos);
    member_port = tbl[IW*int'(pos) +: IW];
  endfunction

  // registers
  logic [15:0]      cfg_q;
  logic [15:0]      cfg_d;
  logic [15:0]      memb_b_q;
  logic [15:0]      memb_b_d;
  logic             ack_q;
  logic [31:0]      rdat_q;
  logic [NPORT-1:0] link_meta_q;
  logic [NPORT-1:0] link_q;
  logic             rsp_valid_q;
  logic [NPORT-1:0] rsp_mask_q;
  logic [2:0]       rsp_idx_q;
  logic             rsp_fail_q;

  // bus decode
  // ack_q masks a request still held after its ack, so it is never taken twice
  wire        bus_req  = WB_CYC_I & WB_STB_I & ~ack_q;
  wire        hit_cfg  = (WB_ADR_I == TRK_CFG_ADDR);
  wire        hit_memb = (WB_ADR_I == TRK_MEMB_B_ADDR);
  wire        hit_st   = (WB_ADR_I == TRK_STATUS_ADDR);
  wire        wr_cfg   = bus_req & WB_WE_I & hit_cfg;
  wire        wr_memb  = bus_req & WB_WE_I & hit_memb;

  // configuration fields
  wire trk_method_t method = trk_method_t'(cfg_q[TRK_METHOD_LSB +: TRK_METHOD_W]);
  wire        seq_on   = cfg_q[TRK_SEQ_BIT];
  wire        dbl      = cfg_q[TRK_DOUBLE_BIT];
  wire [NPORT-1:0] memb_a = cfg_q[TRK_MEMB_LSB +: TRK_MEMB_W];
  wire [NPORT-1:0] memb_b = memb_b_q[TRK_MEMB_LSB +: TRK_MEMB_W];
  // merged group uses the main membership byte; trunk B is ignored then
  wire [NPORT-1:0] memb = (dbl | ~REQ_TRUNK_B) ? memb_a : memb_b;

  // method fallback for packets without an L4 header
  // only the two L4 methods fall back; IP methods hash whatever bits arrive
  trk_method_t eff_method;
  always_comb begin
    eff_method = method;
    if (!REQ_IS_L4 && method == TRK_HASH_L4SRC) begin
      if (seq_on && REQ_IS_IP) begin
        eff_method = TRK_HASH_SIP;
      end else begin
        eff_method = TRK_HASH_SADA;
      end
    end else if (!REQ_IS_L4 && method == TRK_HASH_L4DST) begin
      if (seq_on && REQ_IS_IP) begin
        eff_method = TRK_HASH_DIP;
      end else begin
        eff_method = TRK_HASH_DA;
      end
    end
  end

  // hash identifier, two bits wide for single groups, three for double
  logic [2:0] hash_id;
  always_comb begin
    unique case (eff_method)
      TRK_HASH_PORT:  hash_id = mac_hash(REQ_SRC_PORT[2:0], dbl);
      TRK_HASH_SA:    hash_id = mac_hash(REQ_SA, dbl);
      TRK_HASH_DA:    hash_id = mac_hash(REQ_DA, dbl);
      TRK_HASH_SADA:  hash_id = mac_hash(REQ_SA ^ REQ_DA, dbl);
      TRK_HASH_SIP:   hash_id = fold_hash(REQ_SIP, dbl);
      TRK_HASH_DIP:   hash_id = fold_hash(REQ_DIP, dbl);
      TRK_HASH_L4SRC: hash_id = fold_hash(REQ_L4_SRC, dbl);
      TRK_HASH_L4DST: hash_id = fold_hash(REQ_L4_DST, dbl);
    endcase
  end
  // falls out of the two hash functions: bit 2 stays zero for single groups

  // member table of the addressed trunk
  logic [IW:0]       memb_cnt;
  logic [NPORT*IW-1:0] memb_ports;

  // members are listed by ascending port, so index zero is the lowest member
  trk_pick #(
    .NPORT (NPORT),
    .IW    (IW)
  ) u_pick (
    .mask  (memb),
    .count (memb_cnt),
    .ports (memb_ports)
  );

  // positions: wrapped primary, one lower, then two up from that one
  wire        no_memb  = (memb_cnt == '0);
  wire [IW:0] cnt_nz   = no_memb ? (IW+1)'(1) : memb_cnt;
  wire [IW:0] wrap_w   = (IW+1)'({1'b0, hash_id} % cnt_nz);
  wire [2:0]  pos_pri  = wrap_w[2:0];
  wire [2:0]  last_pos = 3'(cnt_nz - (IW+1)'(1));
  wire [2:0]  pos_dn   = (pos_pri == 3'h0) ? last_pos : pos_pri - 3'h1;
  wire [IW:0] up_w     = (IW+1)'(({1'b0, pos_dn} + 4'h2) % cnt_nz);
  wire [2:0]  pos_up   = up_w[2:0];
  // in a two-member trunk the third candidate is the lower one again and adds nothing

  // link seen at each member position; positions past the member count are dead
  logic [NPORT-1:0] live_pos;
  for (genvar q = 0; q < NPORT; q++) begin : g_live
    assign live_pos[q] = (memb_cnt > (IW+1)'(q)) & link_q[member_port(memb_ports, IW'(q))];
  end

  // candidates in order of preference: primary, one lower, two up from the lower one
  logic [2:0][IW-1:0] cand_pos;
  logic [2:0]         cand_live;
  assign cand_pos[0] = pos_pri;
  assign cand_pos[1] = pos_dn;
  assign cand_pos[2] = pos_up;
  for (genvar c = 0; c < 3; c++) begin : g_cand
    assign cand_live[c] = live_pos[cand_pos[c]];
  end

  // final member position; no live candidate means no egress
  wire [2:0] pos_sel  = cand_live[0] ? pos_pri : (cand_live[1] ? pos_dn : pos_up);
  wire       any_live = ~no_memb & (|cand_live);

  // each member port compares its own index with the packet's index
  logic [NPORT-1:0] port_pos_ok;
  for (genvar p = 0; p < NPORT; p++) begin : g_member
    wire          own_live = (memb_cnt > (IW+1)'(p));
    // a member port forwards only on a matching index
    assign port_pos_ok[p] = own_live & (3'(p) == pos_sel);
  end

  logic [NPORT-1:0] sel_mask;
  always_comb begin
    sel_mask = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (port_pos_ok[p] && any_live) begin
        sel_mask[member_port(memb_ports, IW'(p))] = 1'b1;
      end
    end
  end

  // register write merge honours byte lanes 0 and 1
  always_comb begin
    cfg_d = cfg_q;
    if (wr_cfg && WB_SEL_I[0]) begin
      cfg_d[7:0] = WB_DAT_I[7:0];
    end
    if (wr_cfg && WB_SEL_I[1]) begin
      cfg_d[15:8] = WB_DAT_I[15:8];
    end
  end

  always_comb begin
    memb_b_d = memb_b_q;
    if (wr_memb && WB_SEL_I[0]) begin
      memb_b_d[7:0] = WB_DAT_I[7:0];
    end
    if (wr_memb && WB_SEL_I[1]) begin
      memb_b_d[15:8] = WB_DAT_I[15:8];
    end
  end

  // status word: synced link, last mask, last index, last failover
  logic [31:0] status_w;
  always_comb begin
    status_w                           = 32'h0000_0000;
    status_w[TRK_ST_LINK_LSB +: NPORT] = link_q;
    status_w[TRK_ST_MASK_LSB +: NPORT] = rsp_mask_q;
    status_w[TRK_ST_IDX_LSB +: IW]     = rsp_idx_q;
    status_w[TRK_ST_FAIL_BIT]          = rsp_fail_q;
  end
  // unmapped addresses still ack and read zero, so a stray access never hangs
  wire [31:0] rdat_d = hit_cfg  ? {16'h0000, cfg_q} :
                       hit_memb ? {16'h0000, memb_b_q} :
                       hit_st   ? status_w : 32'h0000_0000;

  // bus slave and configuration
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q    <= TRK_CFG_RST;
      memb_b_q <= TRK_MEMB_B_RST;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end else if (CE) begin
      cfg_q    <= cfg_d;
      memb_b_q <= memb_b_d;
      ack_q    <= bus_req;
      rdat_q   <= rdat_d;
    end
  end

  // link status crosses in through two flops
  // a port that comes up is trusted two clocks later; packets fail over until then
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      link_meta_q <= '0;
      link_q      <= '0;
    end else if (CE) begin
      link_meta_q <= LINK_UP;
      link_q      <= link_meta_q;
    end
  end

  // selection result, one cycle after the request
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_valid_q <= 1'b0;
      rsp_mask_q  <= '0;
      rsp_idx_q   <= 3'h0;
      rsp_fail_q  <= 1'b0;
    end else if (CE) begin
      rsp_valid_q <= REQ_VALID;
      if (REQ_VALID) begin
        rsp_mask_q <= sel_mask;
        rsp_idx_q  <= pos_sel;
        rsp_fail_q <= ~cand_live[0];
      end
    end
  end

  assign WB_ACK_O      = ack_q;
  assign WB_DAT_O      = rdat_q;
  assign RSP_VALID     = rsp_valid_q;
  assign RSP_PORT_MASK = rsp_mask_q;
  assign RSP_INDEX     = rsp_idx_q;
  assign RSP_FAILOVER  = rsp_fail_q;

endmodule
`default_nettype wire

/* File: trk_pkg.sv */
package trk_pkg;

  // register byte addresses on the 32-bit bus
  localparam logic [7:0] TRK_CFG_ADDR    = 8'h1c;
  localparam logic [7:0] TRK_MEMB_B_ADDR = 8'h20;
  localparam logic [7:0] TRK_STATUS_ADDR = 8'h24;

  // trunk_configuration field positions
  localparam int TRK_METHOD_LSB = 0;
  localparam int TRK_METHOD_W   = 3;
  localparam int TRK_SEQ_BIT    = 3;
  localparam int TRK_DOUBLE_BIT = 5;
  localparam int TRK_MEMB_LSB   = 8;
  localparam int TRK_MEMB_W     = 8;

  // status register field positions
  localparam int TRK_ST_LINK_LSB = 0;
  localparam int TRK_ST_MASK_LSB = 8;
  localparam int TRK_ST_IDX_LSB  = 16;
  localparam int TRK_ST_FAIL_BIT = 19;

  // values after reset
  localparam logic [15:0] TRK_CFG_RST    = 16'h0000;
  localparam logic [15:0] TRK_MEMB_B_RST = 16'h0000;

  // hash widths: single groups and the double group
  localparam int TRK_SINGLE_HW = 2;
  localparam int TRK_DOUBLE_HW = 3;

  // pipeline depth of the member selection, in clock cycles
  localparam int TRK_SEL_LATENCY = 1;

  typedef enum logic [2:0] {
    TRK_HASH_PORT  = 3'h0,
    TRK_HASH_SA    = 3'h1,
    TRK_HASH_DA    = 3'h2,
    TRK_HASH_SADA  = 3'h3,
    TRK_HASH_SIP   = 3'h4,
    TRK_HASH_DIP   = 3'h5,
    TRK_HASH_L4SRC = 3'h6,
    TRK_HASH_L4DST = 3'h7
  } trk_method_t;

endpackage

/* File: trk_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module trk_pick #(
  parameter int NPORT = 8,
  parameter int IW    = 3
) (
  // membership vector, one bit per port
  input  wire logic [NPORT-1:0]    mask,
  // members found, and their port numbers in ascending order
  output logic      [IW:0]         count,
  output logic      [NPORT*IW-1:0] ports
);

  always_comb begin
    count = '0;
    ports = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (mask[i]) begin
        ports[IW*int'(count[IW-1:0]) +: IW] = IW'(i);
        count = count + (IW+1)'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: trk_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module trk_link_model (
  // clock and wanted link state
  input  wire logic       clk,
  input  wire logic [7:0] want,
  // per-port link toward the switch
  output logic      [7:0] link
);
  // macs report link changes on their own clock
  always_ff @(posedge clk) link <= want;
endmodule
`default_nettype wire

/* File: trk_load_balance_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module trk_load_balance_checker (
  // watched top ports
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        REQ_VALID,
  input wire logic        RSP_VALID,
  input wire logic [7:0]  RSP_PORT_MASK,
  input wire logic [2:0]  RSP_INDEX,
  input wire logic        RSP_FAILOVER
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_take; CE && WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_pkt; CE && REQ_VALID; endsequence
  property p_ack_resp; s_take |=> WB_ACK_O; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_pulse; s_take ##1 CE |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_dat_hi; WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:20] == 12'h000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("high read bits");
  property p_pkt_resp; s_pkt |=> RSP_VALID; endproperty
  a_pkt_resp: assert property (p_pkt_resp) else $error("no result");
  property p_quiet; CE && !REQ_VALID |=> !RSP_VALID; endproperty
  a_quiet: assert property (p_quiet) else $error("stray result");
  property p_onehot; RSP_VALID |-> $onehot0(RSP_PORT_MASK); endproperty
  a_onehot: assert property (p_onehot) else $error("two ports");
  property p_hold;
    CE && !REQ_VALID |=> $stable(RSP_PORT_MASK) && $stable({RSP_INDEX, RSP_FAILOVER});
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_freeze; !CE |=> $stable({WB_ACK_O, RSP_VALID, RSP_PORT_MASK}); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while off");
endmodule
bind trk_load_balance trk_load_balance_checker u_chk (.MCLK, .RST_N, .CE, .WB_CYC_I,
  .WB_STB_I, .WB_WE_I, .WB_DAT_O, .WB_ACK_O, .REQ_VALID, .RSP_VALID, .RSP_PORT_MASK,
  .RSP_INDEX, .RSP_FAILOVER);
`default_nettype wire

/* File: trk_load_balance_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module trk_load_balance_bench;
  import trk_pkg::*;
  logic        mclk, rst_n, ce, cyc, stb, we, vld, tb_b, is_ip, is_l4, ack, rvld, rfo;
  logic [7:0]  adr, want, link, rmask;
  logic [3:0]  sp, sip, dip, l4s, l4d;
  logic [2:0]  sa, da, ridx;
  logic [3:0]  sel;
  logic [31:0] dw, dr, rd;
  logic [15:0] cfg, mb;
  int          error_cnt, samples_checked, seed, cyc_n;
  trk_load_balance u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw),
    .WB_DAT_O(dr), .WB_ACK_O(ack), .LINK_UP(link), .REQ_VALID(vld), .REQ_TRUNK_B(tb_b),
    .REQ_SRC_PORT(sp), .REQ_SA(sa), .REQ_DA(da), .REQ_SIP(sip), .REQ_DIP(dip),
    .REQ_L4_SRC(l4s), .REQ_L4_DST(l4d), .REQ_IS_IP(is_ip), .REQ_IS_L4(is_l4),
    .RSP_VALID(rvld), .RSP_PORT_MASK(rmask), .RSP_INDEX(ridx), .RSP_FAILOVER(rfo));
  trk_link_model u_link (.clk(mclk), .want(want), .link(link));
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
    // ack and data are read at the edge itself, before the design updates them
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dr;
    {cyc, stb} <= 2'b00;
    if (n >= 50)
      error_cnt++;
  endtask
  function automatic logic [7:0] nth(input logic [7:0] m, input int k);
    for (int i = 0; i < 8; i++)
      if (m[i]) begin
        if (k == 0)
          return 8'h01 << i;
        k--;
      end
    return 8'h00;
  endfunction
  // packs failover, index and one-hot port
  function automatic logic [11:0] want_rsp();
    logic [2:0] m, h;
    logic [3:0] x;
    logic [7:0] g, o;
    int n, p;
    m = cfg[2:0];
    if (m >= 3'h6 && !is_l4)
      m = (cfg[3] && is_ip) ? m - 3'h2 : (m == 3'h6 ? 3'h3 : 3'h2);
    x = m == 0 ? sp : m == 1 ? sa : m == 2 ? da : m == 3 ? sa ^ da :
        m == 4 ? sip : m == 5 ? dip : m == 6 ? l4s : l4d;
    h = m >= 3'h4 ? {x[2] ^ x[1], x[3] ^ x[2], x[1] ^ x[0]} : x[2:0];
    h[2] = h[2] & cfg[5];
    g = (cfg[5] || !tb_b) ? cfg[15:8] : mb[15:8];
    n = $countones(g);
    if (n == 0)
      return 12'h800;
    p = h % n;
    if (nth(g, p) & link)
      return {4'(p), nth(g, p)};
    p = (p + n - 1) % n;
    if (!(nth(g, p) & link))
      p = (p + 2) % n;
    o = nth(g, p);
    return {1'b1, 3'(p), o & link};
  endfunction
  task automatic setup(input int k);
    logic [7:0] a, b;
    logic d;
    d = 1'($random(seed));
    do a = 8'($random(seed)); while ($countones(a) < 2 || (!d && $countones(a) > 4));
    do b = 8'($random(seed)); while ($countones(b) < 2 || $countones(b) > 4);
    cfg = {a, 2'b00, d, 1'b0, 1'($random(seed)), 3'(k)};
    mb = {b, 8'h00};
    bus(1'b1, TRK_CFG_ADDR, {16'h0000, cfg});
    bus(1'b1, TRK_MEMB_B_ADDR, {16'h0000, mb});
    bus(1'b0, TRK_CFG_ADDR, 32'h0);
    chk(rd, {16'h0000, cfg});
    want <= (k % 5 == 0) ? 8'hff : 8'($random(seed) | $random(seed));
    // wait out the link synchroniser
    repeat (4) @(posedge mclk);
    bus(1'b0, TRK_STATUS_ADDR, 32'h0);
    chk(rd[7:0], want);
  endtask
  task automatic burst(input int len);
    logic p;
    logic [11:0] e;
    p = 1'b0;
    e = 12'h000;
    for (int i = 0; i <= len; i++) begin
      @(posedge mclk);
      vld <= (i < len) && ($random(seed) & 3) != 0;
      {tb_b, is_ip, is_l4, sp, sa, da} <= 13'($random(seed));
      {sip, dip, l4s, l4d} <= 16'($random(seed));
      #1;
      chk(rvld, p);
      if (p && e[7:0] == 8'h00)
        chk({rfo, ridx, rmask}, e);
      else if (p)
        chk({rfo, ridx, rmask}, e);
      p = vld;
      e = want_rsp();
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    seed = 32'h1cb3dba6;
    {rst_n, cyc, stb, we, vld, tb_b, is_ip, is_l4, ce} = 9'h001;
    {adr, sp, sa, da, sip, dip, l4s, l4d, dw} = '0;
    sel = 4'h3;
    {want, error_cnt, samples_checked, cyc_n} = {8'hff, 96'h0};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, TRK_CFG_ADDR, 32'h0);
    chk(rd, {16'h0000, TRK_CFG_RST});
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, TRK_CFG_ADDR, 32'hffffff2f);
    bus(1'b0, TRK_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000ff2f);
    sel <= 4'h2;
    bus(1'b1, TRK_CFG_ADDR, 32'h0000_0000);
    sel <= 4'h3;
    bus(1'b0, TRK_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000002f);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      setup(k);
      burst(30);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, TRK_CFG_ADDR, 32'h0);
    chk(rd, {16'h0000, TRK_CFG_RST});
    bus(1'b0, TRK_MEMB_B_ADDR, 32'h0);
    chk(rd, {16'h0000, TRK_MEMB_B_RST});
    chk({rfo, ridx, rmask}, 12'h000);
    stop_test();
  end
endmodule
`default_nettype wire
